/* verilog/sleep_mode_controller.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sleep_consts.svh"
module sleep_mode_controller (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sleep_instr,
    input wire logic sleep_enable_bit,
    input wire logic [2:0] sleep_mode_select,
    input wire logic [`FUSE_W-1:0] clock_source_fuses,
    input wire logic comparator_disable_bit,
    input wire logic converter_enabled,
    input wire logic async_timer_running,
    input wire logic [1:0] async_timer_irq_mask,
    input wire logic global_irq_enable,
    input wire logic [3:0] ext_irq_upper_group,
    input wire logic ext_upper_is_level,
    input wire logic [3:0] ext_irq_lower_group,
    input wire logic pin_change,
    input wire logic twi_addr_match,
    input wire logic twi_irq,
    input wire logic timer_ovf_irq,
    input wire logic serial_tx_irq,
    input wire logic other_io_irq,
    input wire logic comparator_irq,
    input wire logic converter_done_irq,
    input wire logic wdt_irq,
    input wire logic spm_ee_ready_irq,
    input wire logic [1:0] async_timer_events,
    input wire logic ext_reset_req,
    input wire logic wdt_reset_req,
    input wire logic bod_reset_req,
    output logic core_clock_en,
    output logic flash_clock_en,
    output logic io_clock_en,
    output logic osc_en,
    output logic async_timer_clock_en,
    output logic converter_start,
    output logic core_stall,
    output logic core_reset_vector,
    output logic asleep
);
    // =====================================================
    // input synchronisers
    localparam int NS = 29;
    logic [NS-1:0] raw_w, s1_q, s2_q;
    assign raw_w = {ext_irq_upper_group, ext_irq_lower_group, pin_change, twi_addr_match, twi_irq,
                    timer_ovf_irq, serial_tx_irq, other_io_irq, comparator_irq, converter_done_irq,
                    wdt_irq, spm_ee_ready_irq, async_timer_events, ext_reset_req, wdt_reset_req,
                    bod_reset_req, ext_upper_is_level, sleep_instr, async_timer_running,
                    comparator_disable_bit, converter_enabled, async_timer_irq_mask[0]};
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= raw_w;
            s2_q <= s1_q;
        end
    end
    logic [3:0] up_w, lo_w;
    logic pc_w, twm_w, twi_w, tovf_w, stx_w, oio_w, acmp_w, adc_w, wdti_w, spm_w;
    logic [1:0] at_w;
    logic erst_w, wrst_w, brst_w, uplvl_w, slp_w, atrun_w, cmp_off_w, adcen_w, msk0_w;
    assign {up_w, lo_w, pc_w, twm_w, twi_w, tovf_w, stx_w, oio_w, acmp_w, adc_w, wdti_w, spm_w,
            at_w, erst_w, wrst_w, brst_w, uplvl_w, slp_w, atrun_w, cmp_off_w, adcen_w, msk0_w} = s2_q;
    logic [1:0] msk_w;
    assign msk_w = {async_timer_irq_mask[1], msk0_w};

    sleep_pkg::state_t state_q;
    logic [2:0] mode_q;
    logic [3:0] stall_q;
    logic tmr_start_w, tmr_done_w;

    // =====================================================
    // wake qualification
    logic rst_any_w, upper_w;
    assign rst_any_w = erst_w | wrst_w | brst_w;
    assign upper_w = (|up_w) & uplvl_w;

    function automatic logic wake_ok(input logic [2:0] m);
        logic w;
        w = 1'b0;
        case (m)
            `MODE_IDLE: w = (|up_w) | (|lo_w) | pc_w | twm_w | twi_w | tovf_w | stx_w | oio_w
                            | (acmp_w & ~cmp_off_w) | adc_w | wdti_w | spm_w | (|at_w);
            `MODE_QUIET: w = adc_w | wdti_w | twi_w | twm_w | (|at_w) | spm_w | upper_w | pc_w;
            `MODE_PDOWN: w = twm_w | upper_w | (|lo_w) | pc_w;
            `MODE_PSAVE: w = twm_w | upper_w | (|lo_w) | pc_w
                             | (atrun_w & global_irq_enable & (|(at_w & msk_w)));
            default: w = 1'b0;
        endcase
        return w;
    endfunction

    logic enter_w;
    assign enter_w = (state_q == sleep_pkg::ST_RUN) && slp_w && sleep_enable_bit
                     && (sleep_mode_select <= `MODE_PSAVE);
    assign tmr_start_w = (state_q == sleep_pkg::ST_SLEEP) && !rst_any_w && wake_ok(mode_q);

    startup_timer u_startup (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(tmr_start_w),
        .clock_source_fuses(clock_source_fuses),
        .done(tmr_done_w)
    );

    // =====================================================
    // sequencing state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= sleep_pkg::ST_RUN;
            mode_q <= `MODE_IDLE;
            stall_q <= 4'h0;
        end else begin
            case (state_q)
                sleep_pkg::ST_RUN: begin
                    if (enter_w) begin
                        state_q <= sleep_pkg::ST_SLEEP;
                        mode_q <= sleep_mode_select;
                    end
                end
                sleep_pkg::ST_SLEEP: begin
                    if (rst_any_w) begin
                        state_q <= sleep_pkg::ST_RUN;
                    end else if (tmr_start_w) begin
                        state_q <= sleep_pkg::ST_STARTUP;
                    end
                end
                sleep_pkg::ST_STARTUP: begin
                    if (tmr_done_w) begin
                        state_q <= sleep_pkg::ST_STALL;
                        stall_q <= `WAKE_STALL_CYCLES;
                    end
                end
                sleep_pkg::ST_STALL: begin
                    stall_q <= stall_q - 4'h1;
                    if (stall_q == 4'h1) begin
                        state_q <= sleep_pkg::ST_RUN;
                    end
                end
                default: state_q <= sleep_pkg::ST_RUN;
            endcase
        end
    end

    // =====================================================
    // clock gating outputs
    logic sleeping_w;
    assign sleeping_w = (state_q == sleep_pkg::ST_SLEEP);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            core_clock_en <= 1'b1;
            flash_clock_en <= 1'b1;
            io_clock_en <= 1'b1;
            osc_en <= 1'b1;
            async_timer_clock_en <= 1'b1;
            asleep <= 1'b0;
        end else begin
            core_clock_en <= !(enter_w || (state_q != sleep_pkg::ST_RUN && !(state_q == sleep_pkg::ST_STALL
                               && stall_q == 4'h1) && !(sleeping_w && rst_any_w)));
            flash_clock_en <= !(enter_w || (state_q != sleep_pkg::ST_RUN && !(state_q == sleep_pkg::ST_STALL
                                && stall_q == 4'h1) && !(sleeping_w && rst_any_w)));
            io_clock_en <= !((enter_w && sleep_mode_select != `MODE_IDLE)
                             || (sleeping_w && !tmr_start_w && !rst_any_w && mode_q != `MODE_IDLE));
            osc_en <= !((enter_w && sleep_mode_select[1])
                        || (sleeping_w && !tmr_start_w && !rst_any_w && mode_q[1]));
            async_timer_clock_en <= !((enter_w && sleep_mode_select == `MODE_PDOWN)
                                      || (sleeping_w && !tmr_start_w && !rst_any_w && mode_q == `MODE_PDOWN));
            asleep <= enter_w || (sleeping_w && !tmr_start_w && !rst_any_w);
        end
    end

    // =====================================================
    // core control outputs
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            converter_start <= 1'b0;
            core_stall <= 1'b0;
            core_reset_vector <= 1'b0;
        end else begin
            converter_start <= enter_w && adcen_w && !sleep_mode_select[1];
            core_stall <= tmr_start_w || (state_q == sleep_pkg::ST_STARTUP)
                          || (state_q == sleep_pkg::ST_STALL && stall_q != 4'h1);
            core_reset_vector <= sleeping_w && rst_any_w;
        end
    end

    // =====================================================
    // checks
    // no sleep without enable
    AST_NO_SLEEP_WITHOUT_ENABLE: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == sleep_pkg::ST_RUN && !sleep_enable_bit) |=> state_q == sleep_pkg::ST_RUN)
        else $error("sleep entered with enable clear");
    AST_ENTER: assert property (@(posedge ref_clk) disable iff (rst)
        enter_w |=> asleep && !core_clock_en && state_q == sleep_pkg::ST_SLEEP)
        else $error("sleep not entered");
    AST_STALL_FOUR: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == sleep_pkg::ST_STARTUP && tmr_done_w) |=> core_stall [*4] ##1 !core_stall)
        else $error("stall length wrong");
    AST_RESET_WAKE: assert property (@(posedge ref_clk) disable iff (rst)
        (sleeping_w && rst_any_w) |=> core_reset_vector && state_q == sleep_pkg::ST_RUN)
        else $error("reset did not wake");
    AST_IDLE_IO: assert property (@(posedge ref_clk) disable iff (rst)
        (asleep && mode_q == `MODE_IDLE) |-> io_clock_en && osc_en)
        else $error("idle stopped io clock");
    AST_QUIET_IO: assert property (@(posedge ref_clk) disable iff (rst)
        (asleep && mode_q == `MODE_QUIET) |-> !io_clock_en && osc_en)
        else $error("quiet mode clocks wrong");
    AST_PDOWN_OSC: assert property (@(posedge ref_clk) disable iff (rst)
        (asleep && mode_q == `MODE_PDOWN) |-> !osc_en && !async_timer_clock_en)
        else $error("power-down clocks running");
    AST_PSAVE_TMR: assert property (@(posedge ref_clk) disable iff (rst)
        (asleep && mode_q == `MODE_PSAVE) |-> async_timer_clock_en && !osc_en)
        else $error("power-save timer clock off");
    AST_CONV: assert property (@(posedge ref_clk) disable iff (rst)
        (enter_w && adcen_w && sleep_mode_select == `MODE_QUIET) |=> converter_start)
        else $error("conversion not started");
    AST_CLK_BEFORE_RUN: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(core_clock_en) |-> io_clock_en && osc_en)
        else $error("core resumed before clocks");
    COV_IDLE: cover property (@(posedge ref_clk) asleep && mode_q == `MODE_IDLE);
    COV_PDOWN_WAKE: cover property (@(posedge ref_clk) tmr_start_w && mode_q == `MODE_PDOWN);
    COV_RESET_WAKE: cover property (@(posedge ref_clk) core_reset_vector);
endmodule
`default_nettype wire

/* verilog/sleep_consts.svh */
// Functional notes
// - sleep entered only when sleep enable set and sleep instruction executes
// - interrupt wake stalls core four cycles beyond start-up, then resumes
// - reset during sleep wakes device and restarts at reset vector
// - mode 000 idle halts only core and flash clocks
// - idle wakes on any external or internal enabled interrupt
// - comparator disable bit powers comparator down, blocking its idle wake
// - enabled converter starts conversion on entering idle or quiet mode
// - mode 001 quiet mode also halts io clock; converter keeps running
// - quiet mode wakes only on converter, reset, watchdog, twi, spm, async timer, upper-group level, pin sources
// - mode 010 power-down stops oscillator and all generated clocks
// - power-down wakes only on resets, address match, upper-group level, lower group, pin change
// - power-down wake delay set by clock source fuses like reset time-out
// - mode 011 power-save like power-down but async timer keeps counting
// - power-save timer wake needs its mask bit and global enable
`ifndef SLEEP_CONSTS_SVH
`define SLEEP_CONSTS_SVH
`define MODE_IDLE 3'h0
`define MODE_QUIET 3'h1
`define MODE_PDOWN 3'h2
`define MODE_PSAVE 3'h3
`define WAKE_STALL_CYCLES 4'h4
`define FUSE_W 4
`define CNT_W 20
`endif

/* verilog/sleep_pkg.sv */
package sleep_pkg;
    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_SLEEP = 3'b001,
        ST_STARTUP = 3'b010,
        ST_STALL = 3'b011
    } state_t;
endpackage

/* verilog/startup_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sleep_consts.svh"
module startup_timer #(
    parameter int CNT_W = `CNT_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [`FUSE_W-1:0] clock_source_fuses,
    output logic done
);
    logic [CNT_W-1:0] cnt_q;
    logic busy_q;

    function automatic logic [CNT_W-1:0] fuse_delay(input logic [`FUSE_W-1:0] f);
        fuse_delay = CNT_W'(({16'h0, f} + 20'h1) << 4);
    endfunction

    // =====================================================
    // delay counter
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
        end else if (start) begin
            cnt_q <= fuse_delay(clock_source_fuses);
            busy_q <= 1'b1;
        end else if (busy_q) begin
            if (cnt_q == CNT_W'(1)) begin
                busy_q <= 1'b0;
            end
            cnt_q <= cnt_q - CNT_W'(1);
        end
    end

    assign done = busy_q && (cnt_q == CNT_W'(1));
endmodule
`default_nettype wire

/* testbench/core_irq_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// core and interrupt side model
module core_irq_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sleep_go,
    input wire logic [13:0] wake_src,
    input wire logic asleep,
    output logic sleep_instr,
    output logic [13:0] irq_lines
);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sleep_instr <= 1'b0;
        end else begin
            sleep_instr <= sleep_go;
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_lines <= 14'h0;
        end else begin
            irq_lines <= asleep ? wake_src : 14'h0;
        end
    end
endmodule
`default_nettype wire

/* testbench/sleep_mode_controller_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sleep_consts.svh"
module sleep_mode_controller_tb;
    logic ref_clk = 1'b0, rst = 1'b1, go = 1'b0, en = 1'b1, cdis = 1'b0, conv = 1'b1, run = 1'b1, gie = 1'b1;
    logic lvl = 1'b1;
    logic [2:0] mode = 3'h0, rreq = 3'h0;
    logic [1:0] mask = 2'h3;
    logic [`FUSE_W-1:0] fuses = '0;
    logic [13:0] src = 14'h0, irq;
    logic si, cke, fke, ioe, osc, ace, cst, stall, rv, asleep;
    logic [13:0] alw [4] = '{14'h3FFF, 14'h3E15, 14'h000F, 14'h300F};
    logic [13:0] tst [4] = '{14'h3FFF, 14'h3FF7, 14'h3BFF, 14'h3BFF};
    int fails = 0, checks = 0, starts = 0, rvs = 0;
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        starts += (cst === 1'b1);
        rvs += (rv === 1'b1);
    end
    sleep_mode_controller sleep_mode_controller_i (.ref_clk(ref_clk), .rst(rst), .sleep_instr(si),
        .sleep_enable_bit(en), .sleep_mode_select(mode), .clock_source_fuses(fuses),
        .comparator_disable_bit(cdis), .converter_enabled(conv), .async_timer_running(run),
        .async_timer_irq_mask(mask), .global_irq_enable(gie), .ext_irq_upper_group({3'h0, irq[0]}),
        .ext_upper_is_level(lvl), .ext_irq_lower_group({3'h0, irq[1]}), .pin_change(irq[2]),
        .twi_addr_match(irq[3]), .twi_irq(irq[4]), .timer_ovf_irq(irq[5]), .serial_tx_irq(irq[6]),
        .other_io_irq(irq[7]), .comparator_irq(irq[8]), .converter_done_irq(irq[9]), .wdt_irq(irq[10]),
        .spm_ee_ready_irq(irq[11]), .async_timer_events(irq[13:12]), .ext_reset_req(rreq[0]),
        .wdt_reset_req(rreq[1]), .bod_reset_req(rreq[2]), .core_clock_en(cke), .flash_clock_en(fke),
        .io_clock_en(ioe), .osc_en(osc), .async_timer_clock_en(ace), .converter_start(cst),
        .core_stall(stall), .core_reset_vector(rv), .asleep(asleep));
    core_irq_model core_irq_model_i (.ref_clk(ref_clk), .rst(rst), .sleep_go(go), .wake_src(src),
        .asleep(asleep), .sleep_instr(si), .irq_lines(irq));
    // ==========
    // helpers
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic nap(input logic [2:0] m);
        int n;
        n = 0;
        mode = m;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        while (asleep !== 1'b1 && n < 8) begin
            tick(1);
            n++;
        end
    endtask
    task automatic wait_awake();
        int n;
        n = 0;
        while (asleep === 1'b1 && n < 12) begin
            tick(1);
            n++;
        end
    endtask
    task automatic one(input logic [2:0] m, input int s, input logic e);
        int n, c0;
        n = 0;
        c0 = starts;
        fuses = s[`FUSE_W-1:0];
        nap(m);
        chk("asleep", asleep, 1);
        chk("core_flash_clk", {cke, fke}, 0);
        chk("io_clk", ioe, m == 0);
        chk("osc", osc, m < 2);
        chk("async_clk", ace, m != 2);
        src = 14'h1 << s;
        wait_awake();
        chk("woken", asleep === 1'b0, e);
        src = 14'h4;
        wait_awake();
        src = 14'h0;
        chk("io_back", ioe, 1);
        chk("stall_cke", {stall, cke}, 2);
        while (stall === 1'b1 && n < 300) begin
            tick(1);
            n++;
        end
        chk("stall_len", n, (int'(fuses) + 1) * 16 + 4);
        chk("core_back", cke, 1);
        chk("conv_start", starts - c0, m < 2 && conv);
        tick(2);
    endtask
    task automatic end_sim();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ==========
    // watchdog
    initial begin
        #400000;
        fails++;
        end_sim();
    end
    // ==========
    // tests
    initial begin
        tick(4);
        chk("rst_clks", {cke, fke, ioe, osc, ace, asleep, stall}, 7'h7C);
        tick(4);
        rst = 1'b0;
        tick(2);
        $display("test reset done");
        en = 1'b0;
        nap(3'h2);
        tick(4);
        chk("noop", {asleep, cke}, 1);
        en = 1'b1;
        nap(3'h4);
        tick(4);
        chk("mode4", {asleep, cke}, 1);
        $display("test noop done");
        for (int m = 0; m < 4; m++) begin
            for (int s = 0; s < 14; s++) begin
                if (tst[m][s]) begin
                    one(m[2:0], s, alw[m][s]);
                end
            end
        end
        $display("test modes done");
        cdis = 1'b1;
        conv = 1'b0;
        one(3'h0, 8, 1'b0);
        mask = 2'h2;
        one(3'h3, 12, 1'b0);
        mask = 2'h3;
        gie = 1'b0;
        one(3'h3, 13, 1'b0);
        gie = 1'b1;
        run = 1'b0;
        one(3'h2, 0, 1'b1);
        lvl = 1'b0;
        one(3'h1, 0, 1'b0);
        one(3'h2, 0, 1'b0);
        one(3'h0, 0, 1'b1);
        lvl = 1'b1;
        $display("test gating done");
        for (int r = 0; r < 3; r++) begin
            nap(3'h2);
            rreq = 3'h1 << r;
            wait_awake();
            rreq = 3'h0;
            tick(3);
            chk("rst_vec", {asleep, rvs[7:0]}, r + 1);
            tick(300);
        end
        $display("test reset_wake done");
        end_sim();
    end
endmodule
`default_nettype wire
